// >>> verilog/flash_ctl_pkg.sv
// shared constants and types for the flash program/erase control block
package flash_ctl_pkg;

  localparam int          DATA_W        = 16;
  localparam int          ADDR_W        = 4;

  // register offsets (word index on the plain register port)
  localparam logic [3:0]  CTRL_OFS      = 4'h0;
  localparam logic [3:0]  KEY_OFS       = 4'h1;
  localparam logic [3:0]  IRQ_STAT_OFS  = 4'h2;
  localparam logic [3:0]  IRQ_MASK_OFS  = 4'h3;
  localparam logic [3:0]  TARGET_LO_OFS = 4'h4;
  localparam logic [3:0]  TARGET_HI_OFS = 4'h5;

  // control register field positions
  localparam int          TRIG_BIT      = 15;
  localparam int          PROG_EN_BIT   = 14;
  localparam int          SEQ_ERR_BIT   = 13;
  localparam int          ERASE_BIT     = 6;
  localparam logic [15:0] CTRL_IMPL_MASK = 16'hE04F;

  // unlock key values
  localparam logic [7:0]  KEY_FIRST     = 8'h55;
  localparam logic [7:0]  KEY_SECOND    = 8'hAA;

  // operation select codes
  localparam logic [3:0]  OP_BULK_ERASE = 4'hF;
  localparam logic [3:0]  OP_WORD_PROG  = 4'h3;
  localparam logic [3:0]  OP_BLOCK_ERASE = 4'h2;
  localparam logic [3:0]  OP_ROW_PROG   = 4'h1;

  // geometry in bytes, used to align target addresses
  localparam int          ROW_BYTES     = 192;
  localparam int          BLOCK_BYTES   = 1536;

  // operation times in microseconds and derived cycle counts at 10 MHz
  localparam int          CLK_MHZ       = 10;
  localparam int          WORD_US       = 40;
  localparam int          ROW_US        = 2000;
  localparam int          ERASE_US      = 20000;
  localparam int          WORD_CYC      = WORD_US * CLK_MHZ;
  localparam int          ROW_CYC       = ROW_US * CLK_MHZ;
  localparam int          ERASE_CYC     = ERASE_US * CLK_MHZ;
  localparam int          CNT_W         = 24;

  // interrupt status bit positions
  localparam int          IRQ_DONE_BIT  = 0;
  localparam int          IRQ_ERR_BIT   = 1;
  localparam int          IRQ_W         = 2;

  typedef enum logic [2:0] {
    ACT_NONE, ACT_WORD, ACT_ROW, ACT_BLOCK, ACT_BULK
  } flash_action_e;

  // request from sequencer to array timer
  typedef struct packed {
    logic          start;
    flash_action_e action;
    logic [23:0]   addr;
  } array_req_s;

  typedef struct packed {
    logic busy;
    logic done;
  } array_rsp_s;

endpackage

// >>> verilog/unlock_key_check.sv
// two-write unlock key detector for the flash control block
`timescale 1ns/1ps
`default_nettype none
module unlock_key_check
  import flash_ctl_pkg::*;
(
  input  wire logic       clk_in,       // system clock
  input  wire logic       reset_n_in,   // power-on reset, active low
  input  wire logic       key_wr_in,    // write to key register
  input  wire logic [7:0] key_data_in,  // key value written
  input  wire logic       other_acc_in, // any other bus access
  input  wire logic       consume_in,   // trigger attempt consumes unlock
  output logic            unlocked_out, // 55h then AAh seen back to back
  output logic            broken_out    // sequence broken pulse
);

  typedef struct packed {
    logic first_seen;
    logic unlocked;
    logic broken;
  } key_state_s;

  key_state_s s_q;
  key_state_s s_d;

  ////////////////////////////////////////////////////////////////////////
  // key sequence: first key, then second key with no access between
  always_comb begin
    s_d = s_q;
    s_d.broken = 1'b0;
    if (consume_in) begin
      s_d.first_seen = 1'b0;
      s_d.unlocked   = 1'b0;
    end else if (key_wr_in) begin
      s_d.unlocked   = s_q.first_seen && (key_data_in == KEY_SECOND);
      s_d.first_seen = (key_data_in == KEY_FIRST);
      s_d.broken     = s_q.first_seen && (key_data_in != KEY_SECOND);
    end else if (other_acc_in) begin
      s_d.broken     = s_q.first_seen;
      s_d.first_seen = 1'b0;
      s_d.unlocked   = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign unlocked_out = s_q.unlocked;
  assign broken_out   = s_q.broken;

endmodule
`default_nettype wire

// >>> verilog/flash_array_timer.sv
// self-timed array operation timer with address alignment
`timescale 1ns/1ps
`default_nettype none
module flash_array_timer
  import flash_ctl_pkg::*;
#(
  parameter int WORD_CYCLES  = WORD_CYC,
  parameter int ROW_CYCLES   = ROW_CYC,
  parameter int ERASE_CYCLES = ERASE_CYC
) (
  input  wire logic        clk_in,         // system clock
  input  wire logic        reset_n_in,     // power-on reset, active low
  input  wire array_req_s  req_in,         // start request
  output array_rsp_s       rsp_out,        // busy level, done pulse
  output logic [23:0]      aligned_addr_out, // aligned array address
  output logic             commit_out      // latches commit to array
);

  typedef struct packed {
    logic        busy;
    logic        done;
    logic        commit;
    logic [CNT_W-1:0] cnt;
    logic [23:0] addr;
  } timer_state_s;

  timer_state_s s_q;
  timer_state_s s_d;

  // refuse an erase count the counter cannot hold, or word and row counts that make no run at all
  if (ERASE_CYCLES >= (1 << CNT_W) || WORD_CYCLES < 1 || ROW_CYCLES < 1) begin : g_count_check
    $error("flash_array_timer: cycle counts out of range");
  end

  // round an address down to a multiple of the given byte size
  function automatic logic [23:0] align(input logic [23:0] a, input int unsigned sz);
    logic [23:0] m;
    m = 24'((32'(a) / sz) * sz);
    return m;
  endfunction

  // duration per action
  function automatic logic [CNT_W-1:0] dur(input flash_action_e a);
    logic [CNT_W-1:0] d;
    d = CNT_W'(WORD_CYCLES);
    if (a == ACT_ROW) d = CNT_W'(ROW_CYCLES);
    if (a == ACT_BLOCK || a == ACT_BULK) d = CNT_W'(ERASE_CYCLES);
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // count down the operation, commit latched data at the start
  always_comb begin
    s_d = s_q;
    s_d.done   = 1'b0;
    s_d.commit = 1'b0;
    if (!s_q.busy && req_in.start) begin
      s_d.busy   = 1'b1;
      s_d.cnt    = dur(req_in.action);
      s_d.commit = 1'b1;
      unique case (req_in.action)
        ACT_BLOCK: s_d.addr = align(req_in.addr, BLOCK_BYTES);
        ACT_ROW:   s_d.addr = align(req_in.addr, ROW_BYTES);
        ACT_BULK:  s_d.addr = '0;
        default:   s_d.addr = req_in.addr;
      endcase
    end else if (s_q.busy) begin
      if (s_q.cnt <= CNT_W'(1)) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt - CNT_W'(1);
      end
    end
  end

  // state register
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rsp_out.busy     = s_q.busy;
  assign rsp_out.done     = s_q.done;
  assign aligned_addr_out = s_q.addr;
  assign commit_out       = s_q.commit;

endmodule
`default_nettype wire

// >>> verilog/flash_program_erase_control.sv
// flash program/erase control: registers, unlock, trigger and stall
`timescale 1ns/1ps
`default_nettype none

module flash_program_erase_control
  import flash_ctl_pkg::*;
#(
  parameter int WORD_CYCLES  = WORD_CYC,
  parameter int ROW_CYCLES   = ROW_CYC,
  parameter int ERASE_CYCLES = ERASE_CYC
) (
  input  wire logic              clk_in,           // system clock, 10 MHz
  input  wire logic              reset_n_in,       // power-on reset, active low
  input  wire logic              serial_mode_in,   // serial programming mode pin
  input  wire logic [ADDR_W-1:0] reg_addr_in,      // register index
  input  wire logic [DATA_W-1:0] reg_wdata_in,     // write data
  input  wire logic              reg_wr_in,        // write strobe
  input  wire logic              reg_rd_in,        // read strobe
  output logic [DATA_W-1:0]      reg_rdata_out,    // read data, cycle after strobe
  output logic                   cpu_stall_out,    // processor stall level
  output logic                   latch_commit_out, // commit holding latches pulse
  output logic [2:0]             array_op_out,     // action being performed
  output logic [23:0]            array_addr_out,   // aligned array address
  output logic                   irq_out           // level interrupt
);

  ////////////////////////////////////////////////////////////////////////
  // overview
  // - software writes the control register, then the two key values,
  //   then sets the trigger bit in the control register
  // - a trigger is honoured only when the key pair came just before it,
  //   the enable bit in the same write is one and the code is legal
  // - an honoured trigger holds the processor stall high and hands the
  //   action and target to the array timer
  // - the timer commits the holding latches one edge after the start
  //   and counts the run down; its done pulse clears the trigger bit
  // - a refused trigger or a broken key pair sets the error flag and
  //   the error status bit; a finished run sets the done status bit
  // - software cannot abort a run; the stall lasts the full count
  //
  // timing of an honoured trigger, edge by edge
  //   e0:   trigger write sampled; stall and trigger bit rise
  //   e1:   commit pulse and aligned target appear; the action is already out from e0
  //   eN:   timer raises its done pulse
  //   eN+1: trigger bit and stall fall, done status bit set
  //
  // register map, word index on the plain port
  //   0  control: trigger, enable, error, erase, operation code
  //   1  unlock key, write only, reads zero
  //   2  interrupt status, write one to clear: done, error
  //   3  interrupt mask, same layout as the status
  //   4  target address bits 15..0
  //   5  target address bits 23..16
  //   others read zero and ignore writes
  //
  // control register layout
  //   15     trigger, set by software, cleared by hardware
  //   14     program enable
  //   13     sequence error flag
  //   12..7  unused, read zero
  //   6      erase select
  //   5..4   unused, read zero
  //   3..0   operation code
  //
  // refused triggers, each of which sets the error flag
  //   - no unlock, or an access between the two keys
  //   - enable bit clear in the triggering write
  //   - erase bit not matching the code, or an unimplemented code
  //   - bulk erase outside serial programming mode
  //
  // run lengths come from the parameters; the defaults assume the
  // 10 MHz clock, and a slower clock stretches every run in proportion

  ////////////////////////////////////////////////////////////////////////
  // parameter checks, refused at elaboration
  // the timer's width check covers only the erase figure, so it must be the longest of the three
  if (ERASE_CYCLES < ROW_CYCLES || ROW_CYCLES < WORD_CYCLES) begin : g_order_check
    $error("flash_program_erase_control: cycle counts out of order");
  end

  // a word run must last at least one cycle
  if (WORD_CYCLES < 1) begin : g_word_check
    $error("flash_program_erase_control: word cycle count below one");
  end

  // all state of the block outside the key detector and the array timer in one record
  typedef struct packed {
    // software-visible control register fields
    logic              trig;
    logic              prog_en;
    logic              seq_err;
    logic              erase_sel;
    logic [3:0]        op_sel;
    // target address, interrupt status and mask
    logic [23:0]       target;
    logic [IRQ_W-1:0]  irq_stat;
    logic [IRQ_W-1:0]  irq_mask;
    // registered copies of the outputs
    logic              stall;
    logic              irq;
    logic              commit;
    logic [2:0]        op;
    logic [23:0]       aaddr;
    logic [DATA_W-1:0] rdata;
    // two-stage synchroniser for the serial mode pin
    logic              serial_meta;
    logic              serial_sync;
  } ctl_state_s;

  // current and next state
  ctl_state_s s_q;
  ctl_state_s s_d;

  // unlock detector results
  logic        unlocked;
  logic        key_broken;

  // bus access classes
  logic        key_wr;
  logic        other_acc;
  logic        trig_try;

  // array timer request and response
  array_req_s  areq;
  array_rsp_s  arsp;
  logic [23:0] aligned_addr;
  logic        commit;

  // decode operation select and erase bit into an action
  // a code whose erase bit does not match its form decodes to no action,
  // and so does every unimplemented code; no action means a refused start
  function automatic flash_action_e decode_op(input logic [3:0] op, input logic er,
                                              input logic serial);
    flash_action_e a;
    a = ACT_NONE;
    unique case (op)
      OP_WORD_PROG:   a = er ? ACT_NONE : ACT_WORD;
      OP_BLOCK_ERASE: a = er ? ACT_BLOCK : ACT_NONE;
      OP_ROW_PROG:    a = er ? ACT_NONE : ACT_ROW;
      OP_BULK_ERASE:  a = (er && serial) ? ACT_BULK : ACT_NONE;
      default:        a = ACT_NONE;
    endcase
    return a;
  endfunction

  // control register read view
  // gap bits are masked so they read zero whatever the record holds
  function automatic logic [DATA_W-1:0] ctrl_view(input ctl_state_s s);
    logic [DATA_W-1:0] v;
    v = '0;
    v[TRIG_BIT]    = s.trig;
    v[PROG_EN_BIT] = s.prog_en;
    v[SEQ_ERR_BIT] = s.seq_err;
    v[ERASE_BIT]   = s.erase_sel;
    v[3:0]         = s.op_sel;
    return v & CTRL_IMPL_MASK;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // bus access classification
  // a write to the key register feeds the unlock detector
  assign key_wr    = reg_wr_in && (reg_addr_in == KEY_OFS);

  // a trigger attempt is a control write with bit 15 set while idle;
  // writing the bit again during a run is not a new attempt
  assign trig_try  = reg_wr_in && (reg_addr_in == CTRL_OFS) && reg_wdata_in[TRIG_BIT]
                     && !s_q.trig;

  // any other access, read or write, breaks a half-done key pair
  assign other_acc = (reg_wr_in || reg_rd_in) && !key_wr;

  // unlock detector; a trigger attempt consumes the unlock either way
  unlock_key_check u_key (
    .clk_in       (clk_in),
    .reset_n_in   (reset_n_in),
    .key_wr_in    (key_wr),
    .key_data_in  (reg_wdata_in[7:0]),
    .other_acc_in (other_acc && !trig_try),
    .consume_in   (trig_try),
    .unlocked_out (unlocked),
    .broken_out   (key_broken)
  );

  // array timer: aligns the target, commits the latches, times the run
  flash_array_timer #(
    .WORD_CYCLES  (WORD_CYCLES),
    .ROW_CYCLES   (ROW_CYCLES),
    .ERASE_CYCLES (ERASE_CYCLES)
  ) u_timer (
    .clk_in           (clk_in),
    .reset_n_in       (reset_n_in),
    .req_in           (areq),
    .rsp_out          (arsp),
    .aligned_addr_out (aligned_addr),
    .commit_out       (commit)
  );

  ////////////////////////////////////////////////////////////////////////
  // start request to the array timer
  // the action is decoded from the write data, not the stored fields, so
  // a single write can set the code and the trigger together
  // the trigger term in trig_try, not busy, guards the edge between timer done and trigger clear
  always_comb begin
    areq.action = decode_op(reg_wdata_in[3:0], reg_wdata_in[ERASE_BIT], s_q.serial_sync);
    areq.addr   = s_q.target;
    areq.start  = trig_try && unlocked && reg_wdata_in[PROG_EN_BIT]
                  && (areq.action != ACT_NONE) && !arsp.busy;
  end

  ////////////////////////////////////////////////////////////////////////
  // register file and sequencing
  // one pass computes the next record: writes first, then hardware events,
  // so a hardware set of a flag wins over a software clear in one cycle
  always_comb begin
    logic done_ev;
    logic err_ev;
    done_ev = 1'b0;
    err_ev  = 1'b0;
    s_d = s_q;
    // serial mode pin passes two flip-flops before the decoder reads it
    s_d.serial_meta = serial_mode_in;
    s_d.serial_sync = s_q.serial_meta;
    s_d.rdata = '0;
    // timer outputs pass one more register on their way to the pins
    s_d.commit = commit;
    s_d.aaddr  = aligned_addr;

    // writes
    // a control write always updates enable, erase and code fields
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        CTRL_OFS: begin
          s_d.prog_en   = reg_wdata_in[PROG_EN_BIT];
          s_d.erase_sel = reg_wdata_in[ERASE_BIT];
          s_d.op_sel    = reg_wdata_in[3:0];
          // an honoured attempt sets the trigger and clears the error;
          // a refused one leaves the trigger clear and sets the error
          if (trig_try) begin
            if (areq.start) begin
              s_d.trig    = 1'b1;
              s_d.seq_err = 1'b0;
              s_d.op      = areq.action;
            end else begin
              s_d.seq_err = 1'b1;
              err_ev      = 1'b1;
            end
          end else if (!reg_wdata_in[SEQ_ERR_BIT]) begin
            s_d.seq_err = 1'b0;
          end
          // trigger cannot be cleared by a write
        end
        IRQ_STAT_OFS: s_d.irq_stat = s_q.irq_stat & ~reg_wdata_in[IRQ_W-1:0];
        IRQ_MASK_OFS: s_d.irq_mask = reg_wdata_in[IRQ_W-1:0];
        TARGET_LO_OFS: s_d.target[15:0] = reg_wdata_in;
        TARGET_HI_OFS: s_d.target[23:16] = reg_wdata_in[7:0];
        default: ;
      endcase
    end

    // broken key sequence flags an error
    // a broken pair raises the error even when no trigger follows
    if (key_broken) begin
      s_d.seq_err = 1'b1;
      err_ev      = 1'b1;
    end

    // hardware clears trigger on completion
    // the done pulse is one cycle long, so this fires once per run
    if (arsp.done) begin
      s_d.trig = 1'b0;
      s_d.op   = ACT_NONE;
      done_ev  = 1'b1;
    end

    // sticky events, set wins over clear
    // the interrupt level follows the next status and mask, so it needs
    // no extra cycle after a clear or a set
    if (done_ev) s_d.irq_stat[IRQ_DONE_BIT] = 1'b1;
    if (err_ev)  s_d.irq_stat[IRQ_ERR_BIT]  = 1'b1;
    s_d.irq   = |(s_d.irq_stat & s_d.irq_mask);
    // stall rises with the accepted start and falls with the done pulse
    s_d.stall = areq.start || (arsp.busy && !arsp.done);

    // reads
    // read data stand for one cycle after the strobe, zero otherwise;
    // the key register is write only and falls to the zero default
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        CTRL_OFS:      s_d.rdata = ctrl_view(s_q);
        IRQ_STAT_OFS:  s_d.rdata = DATA_W'(s_q.irq_stat);
        IRQ_MASK_OFS:  s_d.rdata = DATA_W'(s_q.irq_mask);
        TARGET_LO_OFS: s_d.rdata = s_q.target[15:0];
        TARGET_HI_OFS: s_d.rdata = DATA_W'(s_q.target[23:16]);
        default:       s_d.rdata = '0;
      endcase
    end
  end

  // state register; only power-on reset clears control bits
  // the block has no other reset input, so no soft reset can reach the
  // trigger, enable, error, erase or code bits
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from flip-flops
  // no logic between the record and the pins
  assign reg_rdata_out    = s_q.rdata;
  assign cpu_stall_out    = s_q.stall;
  assign latch_commit_out = s_q.commit;
  assign array_op_out     = s_q.op;
  assign array_addr_out   = s_q.aaddr;
  assign irq_out          = s_q.irq;

endmodule
`default_nettype wire

// >>> dv/flash_ctl_assertions.sv
// assertions and covers for the flash program/erase control block
`timescale 1ns/1ps
`default_nettype none
module flash_ctl_checker
  import flash_ctl_pkg::*;
(
  input wire logic              clk_in,           // clock
  input wire logic              reset_n_in,       // reset
  input wire logic              serial_mode_in,   // serial mode
  input wire logic [ADDR_W-1:0] reg_addr_in,      // index
  input wire logic [DATA_W-1:0] reg_wdata_in,     // write data
  input wire logic              reg_wr_in,        // write strobe
  input wire logic              reg_rd_in,        // read strobe
  input wire logic [DATA_W-1:0] reg_rdata_out,    // read data
  input wire logic              cpu_stall_out,    // stall
  input wire logic              latch_commit_out, // commit pulse
  input wire logic [2:0]        array_op_out,     // action
  input wire logic [23:0]       array_addr_out,   // target
  input wire logic              irq_out           // interrupt
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  ////////////////////////////////////////////////////////////////////////////
  // register view and start conditions
  a_gaps_zero: assert property ($past(reg_rd_in) && $past(reg_addr_in) == CTRL_OFS |->
    reg_rdata_out[12:7] == 6'h00 && reg_rdata_out[5:4] == 2'h0) else $error("gap bits set");
  a_start_cause: assert property ($rose(cpu_stall_out) |->
    $past(reg_wr_in && reg_addr_in == CTRL_OFS && reg_wdata_in[TRIG_BIT]))
    else $error("stall without trigger");
  a_start_enable: assert property ($rose(cpu_stall_out) |->
    $past(reg_wdata_in[PROG_EN_BIT])) else $error("start while disabled");
  a_start_code: assert property ($rose(cpu_stall_out) |->
    {$past(reg_wdata_in[ERASE_BIT]), $past(reg_wdata_in[3:0])}
      inside {5'h03, 5'h12, 5'h01, 5'h1F}) else $error("start on bad code");
  a_bulk_serial: assert property ($rose(cpu_stall_out) &&
    $past(reg_wdata_in[3:0]) == OP_BULK_ERASE |-> $past(serial_mode_in, 3))
    else $error("bulk erase outside serial mode");

  ////////////////////////////////////////////////////////////////////////////
  // run length, commit and alignment
  a_stall_ends: assert property ($rose(cpu_stall_out) |->
    cpu_stall_out[*2] ##[1:1000] $fell(cpu_stall_out)) else $error("stall not held or stuck");
  a_commit_busy: assert property (latch_commit_out |->
    cpu_stall_out && array_op_out != 3'h0) else $error("commit outside a run");
  a_block_align: assert property (latch_commit_out && array_op_out == ACT_BLOCK |->
    array_addr_out % BLOCK_BYTES == 0) else $error("block target unaligned");
  a_row_align: assert property (latch_commit_out && array_op_out == ACT_ROW |->
    array_addr_out % ROW_BYTES == 0) else $error("row target unaligned");

  // main scenarios
  c_run: cover property ($rose(cpu_stall_out));
  c_block: cover property (latch_commit_out && array_op_out == ACT_BLOCK);
  c_irq: cover property ($rose(irq_out));
endmodule

bind flash_program_erase_control flash_ctl_checker u_flash_ctl_checker (
  .clk_in, .reset_n_in, .serial_mode_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
  .reg_rd_in, .reg_rdata_out, .cpu_stall_out, .latch_commit_out, .array_op_out,
  .array_addr_out, .irq_out);
`default_nettype wire

// >>> dv/tb_flash_program_erase_control.sv
// self-checking bench for the flash program/erase control block
`timescale 1ns/1ps
`default_nettype none
module tb_flash_program_erase_control
  import flash_ctl_pkg::*;
;
  typedef struct packed {
    logic [15:0] ctrl;
    logic        ser;
    logic [2:0]  op;
    logic [23:0] addr;
  } case_s;
  logic              clk_in = 1'b0;
  logic              reset_n_in = 1'b0;
  logic              serial_mode_in = 1'b0;
  logic [ADDR_W-1:0] reg_addr_in = 4'h0;
  logic [DATA_W-1:0] reg_wdata_in = 16'h0000;
  logic              reg_wr_in = 1'b0;
  logic              reg_rd_in = 1'b0;
  logic [DATA_W-1:0] reg_rdata_out;
  logic              cpu_stall_out;
  logic              latch_commit_out;
  logic [2:0]        array_op_out;
  logic [23:0]       array_addr_out;
  logic              irq_out;
  logic [15:0]       rv;
  logic [2:0]        got_op;
  logic [23:0]       got_addr;
  logic              seen;
  int                err_total = 0;
  int                n_tests = 0;
  // target 010D00h: block 010800h, row 010C80h
  case_s rows [12] = '{
    '{16'hC003, 1'b0, 3'h1, 24'h010D00}, '{16'hC001, 1'b0, 3'h2, 24'h010C80},
    '{16'hC042, 1'b0, 3'h3, 24'h010800}, '{16'hC04F, 1'b1, 3'h4, 24'h000000},
    '{16'hC04F, 1'b0, 3'h0, 24'h0}, '{16'hC00F, 1'b1, 3'h0, 24'h0},
    '{16'hC043, 1'b0, 3'h0, 24'h0}, '{16'hC002, 1'b0, 3'h0, 24'h0},
    '{16'hC041, 1'b0, 3'h0, 24'h0}, '{16'hC005, 1'b0, 3'h0, 24'h0},
    '{16'hC04E, 1'b0, 3'h0, 24'h0}, '{16'h8001, 1'b0, 3'h0, 24'h0}};

  // 10 MHz clock
  always #50 clk_in = ~clk_in;

  flash_program_erase_control #(.WORD_CYCLES(4), .ROW_CYCLES(8), .ERASE_CYCLES(16))
    u_flash_program_erase_control (
    .clk_in, .reset_n_in, .serial_mode_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .cpu_stall_out, .latch_commit_out, .array_op_out,
    .array_addr_out, .irq_out);

  ////////////////////////////////////////////////////////////////////////////
  // compare, bus and closing tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, s, e);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // one strobe cycle, launched just after an edge
  task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    reg_wr_in <= w;
    reg_rd_in <= r;
    reg_addr_in <= a;
    reg_wdata_in <= d;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [3:0] a);
    bus(1'b0, 1'b1, a, 16'h0000);
    bus(1'b0, 1'b0, a, 16'h0000);
    #1 rv = reg_rdata_out;
  endtask
  task automatic unlock;
    wr(KEY_OFS, {8'h00, KEY_FIRST});
    wr(KEY_OFS, {8'h00, KEY_SECOND});
  endtask
  // trigger, then watch the run under a bound
  task automatic run(input logic [15:0] c);
    int i;
    wr(CTRL_OFS, c);
    bus(1'b0, 1'b0, 4'h0, 16'h0000);
    got_op = 3'h0;
    got_addr = 24'h0;
    seen = 1'b0;
    for (i = 0; i < 60; i++) begin
      @(posedge clk_in);
      #1;
      if (latch_commit_out === 1'b1) begin
        got_op = array_op_out;
        got_addr = array_addr_out;
      end
      if (cpu_stall_out === 1'b1) seen = 1'b1;
      else if (seen) break;
    end
    if (i == 60 && seen) begin
      err_total++;
      report_and_stop();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (16) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rd(CTRL_OFS);
    chk(rv, 16'h0000);
    rd(4'hF);
    chk(rv, 16'h0000);
    wr(IRQ_MASK_OFS, 16'h0000);
    wr(TARGET_LO_OFS, 16'h0D00);
    wr(TARGET_HI_OFS, 16'h0001);
    bus(1'b0, 1'b0, 4'h0, 16'h0000);
    // every code and mode from the table
    foreach (rows[k]) begin
      @(posedge clk_in);
      serial_mode_in <= rows[k].ser;
      wr(CTRL_OFS, rows[k].ctrl & 16'h7FFF);
      unlock();
      run(rows[k].ctrl);
      chk(seen, rows[k].op != 3'h0);
      chk(got_op, rows[k].op);
      chk(got_addr, rows[k].addr);
      rd(CTRL_OFS);
      chk(rv, (rows[k].ctrl & 16'h404F) | {2'b00, rows[k].op == 3'h0, 13'h0});
    end
    // interrupt: raise, mask, clear
    chk(irq_out, 1'b0);
    rd(IRQ_STAT_OFS);
    chk(rv, 16'h0003);
    wr(IRQ_MASK_OFS, 16'h0001);
    wr(IRQ_STAT_OFS, 16'h0002);
    bus(1'b0, 1'b0, 4'h0, 16'h0000);
    repeat (2) @(posedge clk_in);
    #1 chk(irq_out, 1'b1);
    wr(IRQ_STAT_OFS, 16'h0001);
    bus(1'b0, 1'b0, 4'h0, 16'h0000);
    repeat (2) @(posedge clk_in);
    #1 chk(irq_out, 1'b0);
    // access between keys, then trigger without keys
    wr(KEY_OFS, 16'h0055);
    rd(IRQ_STAT_OFS);
    wr(KEY_OFS, 16'h00AA);
    run(16'hC003);
    chk(seen, 1'b0);
    rd(CTRL_OFS);
    chk(rv, 16'h6003);
    run(16'hC001);
    chk(seen, 1'b0);
    // software write cannot clear a running trigger
    unlock();
    wr(CTRL_OFS, 16'hC042);
    wr(CTRL_OFS, 16'h0042);
    rd(CTRL_OFS);
    chk(rv[15], 1'b1);
    for (int i = 0; i < 60 && cpu_stall_out === 1'b1; i++) begin
      @(posedge clk_in);
      #1;
    end
    #1 chk(cpu_stall_out, 1'b0);
    rd(CTRL_OFS);
    chk(rv, 16'h0042);
    report_and_stop();
  end
endmodule
`default_nettype wire
